// ---- core/mhw_frame_rx.sv ----
// Link frame receiver: samples the host's serial link and judges each frame.
// Assumes link pins are asynchronous to ref_clk and clocked well below a quarter of it.
`timescale 1ns/10ps
`include "mhw_regs.svh"

module mhw_frame_rx (
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire logic               spi_sclk,
   input  wire logic               spi_cs_n,
   input  wire logic               spi_mosi,
   output mhw_pkg::mhw_frame_evt_t frame_evt
);
   import mhw_pkg::*;

   logic [2:0]      sync_a;
   logic [2:0]      sync_b;
   logic            sclk_d;
   mhw_link_state_t state;
   logic [4:0]      bit_cnt;
   logic [15:0]     cmd;
   logic [7:0]      crc_calc;
   logic [7:0]      crc_rx;
   logic            overrun;
   logic            sclk_rise;
   logic            frame_ok;

   // Two flops on each pin; logic reads the second stage, plus a third flop on the link clock for its rising edge.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sync_a <= 3'h2;
         sync_b <= 3'h2;
         sclk_d <= 1'b0;
      end else begin
         sync_a <= {spi_sclk, spi_cs_n, spi_mosi};
         sync_b <= sync_a;
         sclk_d <= sync_b[2];
      end
   end

   assign sclk_rise = sync_b[2] & ~sclk_d;

   // A frame counts only with exact length, a legal command and a matching check byte.
   assign frame_ok = ~overrun && (bit_cnt == `MHW_FRAME_BITS) && (crc_calc == crc_rx)
                     && (cmd[15:12] != `MHW_CMD_ILLEGAL);

   // Frame framing, shifting and the one-cycle verdict at chip-select release.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state     <= MHW_LINK_IDLE;
         bit_cnt   <= 5'h00;
         cmd       <= 16'h0000;
         crc_calc  <= `MHW_CRC_INIT;
         crc_rx    <= 8'h00;
         overrun   <= 1'b0;
         frame_evt <= '0;
      end else begin
         frame_evt <= '0;
         unique case (state)
            MHW_LINK_IDLE: begin
               if (!sync_b[1]) begin
                  state    <= MHW_LINK_SHIFT;
                  bit_cnt  <= 5'h00;
                  crc_calc <= `MHW_CRC_INIT;
                  overrun  <= 1'b0;
               end
            end
            MHW_LINK_SHIFT: begin
               if (sync_b[1]) begin
                  state         <= MHW_LINK_IDLE;
                  frame_evt.good <= frame_ok;
                  frame_evt.bad  <= ~frame_ok;
               end else if (sclk_rise) begin
                  if (bit_cnt < `MHW_CMD_BITS) begin
                     cmd      <= {cmd[14:0], sync_b[0]};
                     crc_calc <= {crc_calc[6:0], 1'b0} ^ ((crc_calc[7] ^ sync_b[0]) ? `MHW_CRC_POLY : 8'h00);
                  end else begin
                     crc_rx <= {crc_rx[6:0], sync_b[0]};
                  end
                  if (bit_cnt == `MHW_FRAME_BITS) begin
                     overrun <= 1'b1;
                  end else begin
                     bit_cnt <= bit_cnt + 5'h01;
                  end
               end
            end
         endcase
      end
   end

endmodule

// ---- core/mhw_host_watchdog.sv ----
// Host-loss watchdog top: register slave, frame-gap timer, event interrupt and pin output.
// Assumes an AXI4-Lite master on ref_clk and the host's serial link pins on separate inputs.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "mhw_regs.svh"

// What this block does
// - The gap timer restarts only on a frame that carries a legal command and a correct check byte.
// - If no such frame arrives within the chosen window, the host counts as lost and the pin goes active.
// - No status or fault flag records host loss; only the pin shows it.
// - Pin zero carries host loss only when configured as output with the watchdog selected as source.
// - The two-bit window field turns detection off at zero and picks one of three windows otherwise.
// - Host loss holds until the window field is written to zero, which also returns the pin to its inactive state.
// - With format zero the pin shows static levels for both active and inactive states.
// - With polarity zero the active state is a low level; polarity one makes it high.
// - With format one the inactive state shows a half-duty square wave as a heartbeat.
module mhw_host_watchdog #(
   parameter int ADDR_W       = 8,
   parameter int WIN1_CYC     = `MHW_WIN1_CYC,
   parameter int WIN2_CYC     = `MHW_WIN2_CYC,
   parameter int WIN3_CYC     = `MHW_WIN3_CYC,
   parameter int PWM_HALF_CYC = `MHW_PWM_HALF_CYC
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   input  wire logic              spi_sclk,
   input  wire logic              spi_cs_n,
   input  wire logic              spi_mosi,
   output logic                   general_pin_zero_out,
   output logic                   general_pin_zero_oe,
   output logic                   irq
);
   import mhw_pkg::*;

   // ********************************
   // Declarations
   // ********************************
   logic [1:0]      host_loss_window_select;
   mhw_pin_cfg_t    pin_cfg;
   logic [1:0]      irq_status;
   logic [1:0]      irq_mask;
   logic [7:0]      good_cnt;
   logic [7:0]      bad_cnt;
   logic [31:0]     gap_cnt;
   logic [31:0]     win_limit;
   logic            host_loss_detect;
   mhw_frame_evt_t  frame_evt;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]     w_data;
   logic [3:0]      w_strb;
   logic            aw_held;
   logic            w_held;
   logic            wr_do;
   logic [7:0]      wr_ofs;
   logic [7:0]      rd_ofs;
   logic            ctrl_wr;
   logic            irq_clr_wr;
   logic            mask_wr;
   logic [1:0]      irq_set;
   logic [1:0]      irq_clr;
   logic [1:0]      next_irq_status;

   // ********************************
   // Link frame receiver and pin stage
   // ********************************

   // Frames are judged in the receiver; only its one-cycle verdicts reach the timer.
   mhw_frame_rx u_frame_rx (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .spi_sclk  (spi_sclk),
      .spi_cs_n  (spi_cs_n),
      .spi_mosi  (spi_mosi),
      .frame_evt (frame_evt)
   );

   // The pin stage registers its outputs, so the pin lags host loss by one cycle.
   mhw_pin_fmt #(
      .PWM_HALF_CYC (PWM_HALF_CYC)
   ) u_pin_fmt (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .pin_cfg   (pin_cfg),
      .host_loss (host_loss_detect),
      .pin_out   (general_pin_zero_out),
      .pin_oe    (general_pin_zero_oe)
   );

   // ********************************
   // Write channel
   // ********************************

   // Address and data may come in either order; each is held until both are present.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_do) begin
         aw_held <= 1'b0;
      end
   end

   // Data side of the write, captured with its byte strobes.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_do) begin
         w_held <= 1'b0;
      end
   end

   // Ready flags are registered; they drop on a handshake and return once the response is gone.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
         end else if (!aw_held && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
         end else if (!w_held && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   assign wr_do      = aw_held && w_held && !s_axi_bvalid;
   assign wr_ofs     = 8'(aw_addr);
   assign ctrl_wr    = wr_do && (wr_ofs == `MHW_CTRL_OFS) && w_strb[0];
   assign irq_clr_wr = wr_do && (wr_ofs == `MHW_IRQ_STAT_OFS) && w_strb[0];
   assign mask_wr    = wr_do && (wr_ofs == `MHW_IRQ_MASK_OFS) && w_strb[0];

   // One write at a time; unmapped offsets answer with a slave error.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `MHW_RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         if ((wr_ofs == `MHW_CTRL_OFS) || (wr_ofs == `MHW_STAT_OFS) ||
             (wr_ofs == `MHW_IRQ_STAT_OFS) || (wr_ofs == `MHW_IRQ_MASK_OFS)) begin
            s_axi_bresp <= `MHW_RESP_OKAY;
         end else begin
            s_axi_bresp <= `MHW_RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ********************************
   // Control and mask registers
   // ********************************

   // Control fields all sit in byte lane zero, so only that strobe matters.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {pin_cfg, host_loss_window_select} <= `MHW_CTRL_RESET;
      end else if (ctrl_wr) begin
         host_loss_window_select <= w_data[`MHW_CTRL_WIN_LSB +: 2];
         pin_cfg.polarity        <= w_data[`MHW_CTRL_POL_BIT];
         pin_cfg.direction       <= w_data[`MHW_CTRL_DIR_BIT];
         pin_cfg.source_select   <= w_data[`MHW_CTRL_SRC_BIT];
         pin_cfg.output_format   <= w_data[`MHW_CTRL_FMT_BIT];
         pin_cfg.soft_level      <= w_data[`MHW_CTRL_SOFT_BIT];
      end
   end

   // Interrupt mask, same layout as the event status.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_mask <= `MHW_IRQ_RESET;
      end else if (mask_wr) begin
         irq_mask <= w_data[1:0];
      end
   end

   // ********************************
   // Gap timer
   // ********************************

   // Window length chosen by the select field; zero means detection is off.
   always_comb begin
      unique case (host_loss_window_select)
         2'h1: win_limit = 32'(WIN1_CYC);
         2'h2: win_limit = 32'(WIN2_CYC);
         2'h3: win_limit = 32'(WIN3_CYC);
         2'h0: win_limit = 32'h0000_0000;
      endcase
   end

   // Host loss latches on timeout and is only released by turning detection off.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         gap_cnt          <= 32'h0000_0000;
         host_loss_detect <= 1'b0;
      end else if (host_loss_window_select == `MHW_WIN_OFF) begin
         gap_cnt          <= 32'h0000_0000;
         host_loss_detect <= 1'b0;
      end else if (!host_loss_detect) begin
         if (frame_evt.good) begin
            gap_cnt <= 32'h0000_0000;
         end else if (gap_cnt >= win_limit - 32'h0000_0001) begin
            host_loss_detect <= 1'b1;
         end else begin
            gap_cnt <= gap_cnt + 32'h0000_0001;
         end
      end
   end

   // ********************************
   // Frame events and interrupt
   // ********************************

   // Only frame verdicts raise events; host loss has no flag by design.
   assign irq_set = {frame_evt.bad, frame_evt.good};
   assign irq_clr = irq_clr_wr ? w_data[1:0] : 2'h0;
   // A new event in the clearing cycle survives the clear.
   assign next_irq_status = (irq_status & ~irq_clr) | irq_set;

   // Sticky event bits and the level interrupt, both registered.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_status <= `MHW_IRQ_RESET;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq        <= |(next_irq_status & irq_mask);
      end
   end

   // Wrapping counters of judged frames, readable for link diagnosis.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         good_cnt <= 8'h00;
         bad_cnt  <= 8'h00;
      end else begin
         if (frame_evt.good) begin
            good_cnt <= good_cnt + 8'h01;
         end
         if (frame_evt.bad) begin
            bad_cnt <= bad_cnt + 8'h01;
         end
      end
   end

   // ********************************
   // Read channel
   // ********************************

   assign rd_ofs = 8'(s_axi_araddr);

   // Address ready is registered and held low while a read answer is pending.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // Read data is sampled at the address handshake; the status word holds no loss bit.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `MHW_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `MHW_RESP_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
         unique case (rd_ofs)
            `MHW_CTRL_OFS:     s_axi_rdata <= {25'h0, pin_cfg.soft_level, pin_cfg.output_format,
                                               pin_cfg.source_select, pin_cfg.direction,
                                               pin_cfg.polarity, host_loss_window_select};
            `MHW_STAT_OFS:     s_axi_rdata <= {8'h00, bad_cnt, good_cnt, 6'h00, host_loss_window_select};
            `MHW_IRQ_STAT_OFS: s_axi_rdata <= {30'h0, irq_status};
            `MHW_IRQ_MASK_OFS: s_axi_rdata <= {30'h0, irq_mask};
            default:           s_axi_rresp <= `MHW_RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ---- core/mhw_pin_fmt.sv ----
// Output stage of general pin zero: source choice, polarity, static or heartbeat format.
// Assumes the host-loss level and configuration come from logic on ref_clk.
`timescale 1ns/10ps
`include "mhw_regs.svh"

module mhw_pin_fmt #(
   parameter int PWM_HALF_CYC = `MHW_PWM_HALF_CYC
) (
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  mhw_pkg::mhw_pin_cfg_t    pin_cfg,
   input  wire logic                host_loss,
   output logic                     pin_out,
   output logic                     pin_oe
);
   import mhw_pkg::*;

   logic [31:0] pwm_cnt;
   logic        pwm_level;

   // Free-running square wave at half duty, used as the heartbeat.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pwm_cnt   <= 32'h0000_0000;
         pwm_level <= 1'b0;
      end else if (pwm_cnt == 32'(PWM_HALF_CYC - 1)) begin
         pwm_cnt   <= 32'h0000_0000;
         pwm_level <= ~pwm_level;
      end else begin
         pwm_cnt <= pwm_cnt + 32'h0000_0001;
      end
   end

   // Pin drive; the pin only carries host loss as an output with the watchdog as source.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else if (!pin_cfg.direction) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else begin
         pin_oe <= 1'b1;
         if (pin_cfg.source_select) begin
            pin_out <= pin_cfg.soft_level;
         end else if (host_loss) begin
            pin_out <= pin_cfg.polarity;
         end else if (pin_cfg.output_format) begin
            pin_out <= pwm_level;
         end else begin
            pin_out <= ~pin_cfg.polarity;
         end
      end
   end

endmodule

// ---- inc/mhw_pkg.sv ----
// Types shared by the host-loss watchdog modules.
// Assumes the constants header is on the include path.
package mhw_pkg;

   // ********************************
   // Carriers and states
   // ********************************
   typedef struct packed {
      logic polarity;
      logic direction;
      logic source_select;
      logic output_format;
      logic soft_level;
   } mhw_pin_cfg_t;

   typedef struct packed {
      logic good;
      logic bad;
   } mhw_frame_evt_t;

   typedef enum logic [0:0] {
      MHW_LINK_IDLE  = 1'b0,
      MHW_LINK_SHIFT = 1'b1
   } mhw_link_state_t;

endpackage

// ---- inc/mhw_regs.svh ----
// Register offsets, field positions, reset values and timing figures of the host-loss watchdog.
// Assumes a 100 MHz core clock and a register bus with 32-bit words at byte addresses.
`ifndef MHW_REGS_SVH
`define MHW_REGS_SVH

// ********************************
// Register offsets (byte addresses)
// ********************************
`define MHW_CTRL_OFS        8'h00
`define MHW_STAT_OFS        8'h04
`define MHW_IRQ_STAT_OFS    8'h08
`define MHW_IRQ_MASK_OFS    8'h0C

// ********************************
// Field positions and reset values
// ********************************
`define MHW_CTRL_WIN_LSB    0
`define MHW_CTRL_POL_BIT    2
`define MHW_CTRL_DIR_BIT    3
`define MHW_CTRL_SRC_BIT    4
`define MHW_CTRL_FMT_BIT    5
`define MHW_CTRL_SOFT_BIT   6
`define MHW_CTRL_RESET      7'h00
`define MHW_WIN_OFF         2'h0
`define MHW_IRQ_GOOD_BIT    0
`define MHW_IRQ_BAD_BIT     1
`define MHW_IRQ_RESET       2'h0
`define MHW_STAT_GOOD_LSB   8
`define MHW_STAT_BAD_LSB    16
`define MHW_RESP_OKAY       2'h0
`define MHW_RESP_SLVERR     2'h2

// ********************************
// Link frame layout
// ********************************
`define MHW_FRAME_BITS      5'h18
`define MHW_CMD_BITS        5'h10
`define MHW_CRC_INIT        8'hFF
`define MHW_CRC_POLY        8'h07
`define MHW_CMD_ILLEGAL     4'hF

// ********************************
// Timing figures and cycle counts
// ********************************
`define MHW_CLK_KHZ         100000
`define MHW_WIN1_MS         1
`define MHW_WIN2_MS         10
`define MHW_WIN3_MS         100
`define MHW_PWM_HALF_US     500
`define MHW_WIN1_CYC        (`MHW_WIN1_MS * `MHW_CLK_KHZ)
`define MHW_WIN2_CYC        (`MHW_WIN2_MS * `MHW_CLK_KHZ)
`define MHW_WIN3_CYC        (`MHW_WIN3_MS * `MHW_CLK_KHZ)
`define MHW_PWM_HALF_CYC    ((`MHW_PWM_HALF_US * `MHW_CLK_KHZ) / 1000)

`endif

// ---- test/mhw_host_model.sv ----
// Host model on the serial link: sends frames of up to 24 bits, MSB first.
// Assumes the bench calls send_frame from its single main sequence.
`timescale 1ns/10ps

module mhw_host_model (
   output logic sclk,
   output logic cs_n,
   output logic mosi
);
   // The link clock rests low between frames.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // A deselected data line toggles, so no stale bit passes.
   always #40 if (cs_n) mosi = ~mosi;

   // Sends the top n bits of w at an 80 ns link period.
   task automatic send_frame(input logic [23:0] w, input int n);
      #3 cs_n = 1'b0;
      for (int i = 23; i > 23 - n; i--) begin
         mosi = w[i];
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
      end
      #40 cs_n = 1'b1;
      #100;
   endtask
endmodule

// ---- test/mhw_host_watchdog_asserts.sv ----
// Port checker of the host-loss watchdog: bus handshakes and pin enable.
// Assumes it is bound to the watchdog top, one clock domain.
`timescale 1ns/10ps

module mhw_host_watchdog_asserts #(
   parameter int ADDR_W = 8
) (
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              general_pin_zero_out,
   input wire logic              general_pin_zero_oe,
   input wire logic              irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Leaving reset must find the pin undriven and nothing pending.
   idle_after_reset_a: assert property ($fell(rst) |-> !irq && !general_pin_zero_oe && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs busy after reset");
   pin_quiet_a: assert property (!general_pin_zero_oe |-> !general_pin_zero_out)
      else $error("pin level while not driven");
   aw_once_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("write address taken twice");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   r_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule

bind mhw_host_watchdog mhw_host_watchdog_asserts #(.ADDR_W(ADDR_W)) u_chk (.ref_clk, .rst, .s_axi_awvalid,
   .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .general_pin_zero_out, .general_pin_zero_oe, .irq);

// ---- test/mhw_host_watchdog_tb_top.sv ----
// Bench of the host-loss watchdog: register bus tasks, link frames, pin checks.
// Assumes package, header, design and host model are compiled first.
`timescale 1ns/10ps
`include "mhw_regs.svh"

module mhw_host_watchdog_tb_top;
   import mhw_pkg::*;
   localparam int W1 = 1000;
   localparam int W2 = 2000;
   localparam int W3 = 3000;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, p;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd_val;
   logic [1:0]  bresp, rresp, resp;
   logic        awready, wready, bvalid, arready, rvalid, pin, oe, irq, sclk, cs_n, mosi;
   int          err_total = 0;
   int          tests_run = 0;
   int          hi;
   int          win[4] = '{0, W1, W2, W3};
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end

   always #5 ref_clk = ~ref_clk;

   mhw_host_watchdog #(.WIN1_CYC(W1), .WIN2_CYC(W2), .WIN3_CYC(W3), .PWM_HALF_CYC(10)) u_dut (
      .ref_clk(ref_clk), .rst(rst), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
      .general_pin_zero_out(pin), .general_pin_zero_oe(oe), .irq(irq));

   mhw_host_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));

   // Register write; each channel drops at its own handshake.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   // Register read; data is taken at the edge where it is seen.
   task automatic rd(input logic [7:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd_val = rdata;
      resp = rresp;
      rready <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   // Check byte of a command, from the rules.
   function automatic logic [7:0] crc8(input logic [15:0] c);
      logic [7:0] r;
      r = 8'hFF;
      for (int i = 15; i >= 0; i--) r = {r[6:0], 1'b0} ^ ((r[7] ^ c[i]) ? 8'h07 : 8'h00);
      return r;
   endfunction

   task automatic frame(input logic [15:0] c, input logic [7:0] k, input int n);
      u_host.send_frame({c, crc8(c) ^ k}, n);
      repeat (10) @(posedge ref_clk);
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // The whole run needs about 13000 cycles; over seven times that means a hang.
   initial begin
      #1000000;
      err_total++;
      give_verdict;
   end

   // Main sequence of tests.
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rd(`MHW_CTRL_OFS);
      `CHK("ctrl reset", 32'h0, rd_val)
      `CHK("pin reset", 2'b00, {oe, pin})
      rd(8'h10);
      `CHK("unmapped read", 2'h2, resp)
      wr(8'h10, 32'h1);
      `CHK("unmapped write", 2'h2, resp)
      $display("test reset done");
      wr(`MHW_IRQ_MASK_OFS, 32'h3);
      wr(`MHW_CTRL_OFS, 32'h9);
      frame(16'h1234, 8'h0, 24);
      rd(`MHW_IRQ_STAT_OFS);
      `CHK("good event", 33'h100000001, {irq, rd_val})
      wr(`MHW_IRQ_STAT_OFS, 32'h1);
      `CHK("irq cleared", 1'b0, irq)
      wr(`MHW_IRQ_MASK_OFS, 32'h2);
      repeat (6) frame(16'h1234, 8'h0, 24);
      `CHK("host present", 3'b110, {oe, pin, irq})
      // Bad check byte, illegal command and short frame, twice each.
      for (int i = 0; i < 6; i++) frame((i % 3 == 1) ? 16'hF123 : 16'h1234,
         {7'h0, i % 3 == 0}, (i % 3 == 2) ? 23 : 24);
      `CHK("host lost", 3'b101, {oe, pin, irq})
      rd(`MHW_STAT_OFS);
      `CHK("status", 32'h00060701, rd_val)
      wr(`MHW_IRQ_STAT_OFS, 32'h3);
      frame(16'h1234, 8'h0, 24);
      `CHK("loss held", 2'b00, {pin, irq})
      wr(`MHW_CTRL_OFS, 32'h8);
      `CHK("loss released", 1'b1, pin)
      $display("test frames done");
      for (int c = 1; c < 4; c++) begin
         p = (c == 2);
         wr(`MHW_CTRL_OFS, 32'h8 | {p, 2'b00} | c);
         frame(16'h0042, 8'h0, 24);
         repeat (win[c] - 40) @(posedge ref_clk);
         `CHK("before expiry", !p, pin)
         repeat (60) @(posedge ref_clk);
         `CHK("after expiry", p, pin)
         wr(`MHW_CTRL_OFS, 32'h8 | {p, 2'b00});
         `CHK("cleared", !p, pin)
      end
      repeat (W1 + 100) @(posedge ref_clk);
      `CHK("detection off", 1'b1, pin)
      $display("test windows done");
      wr(`MHW_CTRL_OFS, 32'h29);
      hi = 0;
      repeat (40) begin @(posedge ref_clk); hi += pin; end
      `CHK("heartbeat", 20, hi)
      repeat (W1 + 50) @(posedge ref_clk);
      hi = 0;
      repeat (40) begin @(posedge ref_clk); hi += pin; end
      `CHK("static active", 0, hi)
      wr(`MHW_CTRL_OFS, 32'h59);
      repeat (W1 + 50) @(posedge ref_clk);
      `CHK("other source", 2'b11, {oe, pin})
      wr(`MHW_CTRL_OFS, 32'h1);
      `CHK("input pin", 2'b00, {oe, pin})
      $display("test pin done");
      give_verdict;
   end
endmodule
